// *** rtl/sfr_pkg.sv ***
// Shared constants for the serial flash read and program front end.
// Assumes a single system clock that oversamples the host serial clock.
package sfr_pkg;

    // Opcodes; the second of each array read and program pair always takes a four byte address.
    localparam logic [7:0] OP_CFG_NV = 8'hb5;
    localparam logic [7:0] OP_CFG_V  = 8'h85;
    localparam logic [7:0] OP_EAR    = 8'hc8;
    localparam logic [7:0] OP_RD3    = 8'h03;
    localparam logic [7:0] OP_RD4    = 8'h13;
    localparam logic [7:0] OP_FAST3  = 8'h0b;
    localparam logic [7:0] OP_FAST4  = 8'h0c;
    localparam logic [7:0] OP_QOUT3  = 8'h6b;
    localparam logic [7:0] OP_QOUT4  = 8'h6c;
    localparam logic [7:0] OP_QIO3   = 8'heb;
    localparam logic [7:0] OP_QIO4   = 8'hec;
    localparam logic [7:0] OP_DTR3   = 8'hed;
    localparam logic [7:0] OP_DTR4   = 8'hee;
    localparam logic [7:0] OP_PROG3  = 8'h02;
    localparam logic [7:0] OP_PROG4  = 8'h12;

    // Address lengths in bits, and bits per byte.
    localparam logic [5:0] ABITS_SHORT = 6'h18;
    localparam logic [5:0] ABITS_LONG  = 6'h20;
    localparam logic [5:0] BYTE_BITS   = 6'h08;

    // Dummy clocks after address, mode byte or opcode.
    localparam logic [3:0] DUM_CFG_SER  = 4'h8;
    localparam logic [3:0] DUM_CFG_QUAD = 4'h2;
    localparam logic [3:0] DUM_EAR_FAST = 4'h8;
    localparam logic [3:0] DUM_FAST     = 4'h8;
    localparam logic [3:0] DUM_QIO      = 4'h4;
    localparam logic [3:0] DUM_DTR      = 4'h6;

    // Wrap section lengths and page size.
    localparam logic [1:0] WRAP_16   = 2'h0;
    localparam logic [1:0] WRAP_32   = 2'h1;
    localparam logic [7:0] MASK_16   = 8'h0f;
    localparam logic [7:0] MASK_32   = 8'h1f;
    localparam logic [7:0] MASK_64   = 8'h3f;
    localparam logic [8:0] PAGE_SIZE = 9'h100;

    // Forbidden continuous read mode pattern.
    localparam logic [1:0] CRM_BAD = 2'h2;

    // Synchroniser reset: serial clock low, chip select high.
    localparam logic [5:0] SYNC_RST = 6'h02;

    // Sequencer states.
    typedef enum logic [7:0] {
        S_IDLE  = 8'h01,
        S_CMD   = 8'h02,
        S_ADDR  = 8'h04,
        S_MODE  = 8'h08,
        S_DUMMY = 8'h10,
        S_DOUT  = 8'h20,
        S_DIN   = 8'h40,
        S_IGN   = 8'h80
    } sfr_state_t;

endpackage

// *** rtl/sfr_sync.sv ***
// Two flip-flop synchroniser for a group of asynchronous pin levels.
// Assumes each bit is a slow level; no multi-bit coherence is promised.
`timescale 1ns/1ps
module sfr_sync #(
    parameter int         W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    // Clock and reset.
    input  wire logic         clk_i,
    input  wire logic         resetn_i,
    // Asynchronous levels in, synchronised levels out.
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    // First stage; only the second stage reads it.
    logic [W-1:0] meta_r;

    // Both stages reset to the idle pin levels.
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            meta_r <= RST;
            q_o    <= RST;
        end
        else
        begin
            meta_r <= d_i;
            q_o    <= meta_r;
        end
    end

endmodule

// *** rtl/sfr_page_buf.sv ***
// Page buffer: 256 bytes, one write port, one registered read port.
// Assumes the program engine reads it only after a frame has ended.
`timescale 1ns/1ps
module sfr_page_buf (
    // Clock.
    input  wire logic       clk_i,
    // Write port from the serial side.
    input  wire logic       we_i,
    input  wire logic [7:0] waddr_i,
    input  wire logic [7:0] wdata_i,
    // Read port for the program engine.
    input  wire logic [7:0] raddr_i,
    output logic      [7:0] rdata_o
);

    // Storage; contents are undefined until written.
    logic [7:0] mem_r [256];

    // A write lands in the cycle of its strobe.
    always_ff @(posedge clk_i)
    begin
        if (we_i)
        begin
            mem_r[waddr_i] <= wdata_i;
        end
    end

    // Read data comes out one cycle after the address.
    always_ff @(posedge clk_i)
    begin
        rdata_o <= mem_r[raddr_i];
    end

endmodule

// *** rtl/sfr_core.sv ***
// Serial flash command front end: reads, register reads and page load.
// Assumes clk_i runs at least eight times faster than the serial clock.
// Functional notes
// - Config read: opcode, address, dummy byte, then data; in quad mode the dummy phase never ends
// - Config value shifts out on falling edges
// - Config read refused while internal cycle busy
// - Extended register read returns byte MSB first
// - Quad mode fast clock: eight dummy clocks; the count steps by four per clock, so count plus one never equals eight
// - Four byte mode ignores extended address register
// - Normal read: address then data, no dummy
// - Read address advances one per output byte
// - Normal read refused while internal cycle busy
// - Fast read: address, dummy clocks, then data; in quad mode the dummy phase never ends
// - Quad output read: serial address, nibble data; in quad mode the dummy phase never ends
// - Quad I/O read: nibble address, mode, dummy
// - Wrap enabled: output stays in its section; only quad I/O and DTR reads wrap, and neither reaches output
// - DTR read moves nibbles on both edges
// - DTR read address rolls over to zero; DTR reads stay in the dummy phase, so the address never advances
// - DTR read refused while internal cycle busy
// - Page program: opcode, address, data bytes
// - Page data past end wraps to page start
// - Address select flag picks 24 or 32 bits
// - Short mode takes top byte from extended register
// - Over 256 bytes: last 256 are kept
// - Program only if select rises on byte boundary
`timescale 1ns/1ps
module sfr_core
    import sfr_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    // Serial pins from the host; io_i[0] is SI, io[1] is SO.
    input  wire logic        sclk_i,
    input  wire logic        cs_n_i,
    input  wire logic [3:0]  io_i,
    output logic      [3:0]  io_o,
    output logic      [3:0]  io_oe_o,
    // Device state seen by the sequencer.
    input  wire logic        write_in_progress_flag_i,
    input  wire logic        write_enable_latch_i,
    input  wire logic        long_address_select_i,
    input  wire logic        quad_command_mode_i,
    input  wire logic        sclk_fast_i,
    input  wire logic        wrap_en_i,
    input  wire logic [1:0]  wrap_len_i,
    input  wire logic [7:0]  ext_addr_i,
    // Array and configuration register read port.
    output logic      [31:0] mem_addr_o,
    input  wire logic [7:0]  mem_data_i,
    input  wire logic [7:0]  cfg_data_i,
    // Status.
    output logic             reject_o,
    // Page program hand-off.
    output logic             prog_start_o,
    output logic      [31:0] prog_addr_o,
    output logic      [8:0]  prog_len_o,
    input  wire logic [7:0]  pb_raddr_i,
    output logic      [7:0]  pb_rdata_o
);

    // Synchronised pins and a delayed serial clock copy for edge finding.
    logic [5:0]  pins_s;
    logic        sclk_s, csn_s;
    logic [3:0]  io_s;
    logic        sclk_d_r;
    logic        rise, fall;

    // Sequencer state.
    sfr_state_t  st_r;
    logic [5:0]  bits_r;      // Bits or dummy clocks counted in this phase.
    logic [31:0] sh_r;        // Input shift register.
    logic [31:0] sh_nxt;
    logic [7:0]  op_r;        // Opcode of the frame.
    logic [31:0] addr_r;      // Current byte address.
    logic [7:0]  mode_r;      // Continuous read mode byte.

    // Output shifter.
    logic [7:0]  ob_r;
    logic [3:0]  obits_r;     // Bits still to send of the current byte.
    logic [7:0]  cur_byte;
    logic [7:0]  src_byte;

    // Page program bookkeeping.
    logic [7:0]  col_r;       // Next buffer column to write.
    logic [7:0]  scol_r;      // Column of the first data byte.
    logic [8:0]  pcnt_r;      // Bytes loaded, saturating at one page.

    // Opcode decode and phase figures.
    logic [7:0]  opc;
    logic        is_cfg, is_ear, is_rd, is_fast, is_qout, is_qio, is_dtr, is_prog;
    logic        four_b, is_arr, known;
    logic        lanes4, out4;
    logic [5:0]  inc, abits, bits_inc;
    logic [3:0]  dum;
    logic        samp, oedge, addr_done, byte_done, disp, disp_ign;
    logic [31:0] a_new, addr_adv;
    logic [7:0]  wmask;

    // All pins pass two flip-flops before any logic looks at them.
    sfr_sync #(.W(6), .RST(SYNC_RST)) u_sync (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .d_i      ({io_i, cs_n_i, sclk_i}),
        .q_o      (pins_s)
    );
    assign sclk_s = pins_s[0];
    assign csn_s  = pins_s[1];
    assign io_s   = pins_s[5:2];

    // Serial clock edges are found against a delayed copy.
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            sclk_d_r <= 1'b0;
        end
        else
        begin
            sclk_d_r <= sclk_s;
        end
    end
    assign rise = sclk_s & ~sclk_d_r;
    assign fall = ~sclk_s & sclk_d_r;

    // The opcode is decoded from the shifter while it is being received.
    always_comb
    begin
        opc     = (st_r == S_CMD) ? sh_r[7:0] : op_r;
        is_cfg  = (opc == OP_CFG_NV) || (opc == OP_CFG_V);
        is_ear  = (opc == OP_EAR);
        is_rd   = (opc == OP_RD3) || (opc == OP_RD4);
        is_fast = (opc == OP_FAST3) || (opc == OP_FAST4);
        is_qout = (opc == OP_QOUT3) || (opc == OP_QOUT4);
        is_qio  = (opc == OP_QIO3) || (opc == OP_QIO4);
        is_dtr  = (opc == OP_DTR3) || (opc == OP_DTR4);
        is_prog = (opc == OP_PROG3) || (opc == OP_PROG4);
        four_b  = (opc == OP_RD4) || (opc == OP_FAST4) || (opc == OP_QOUT4)
                || (opc == OP_QIO4) || (opc == OP_DTR4) || (opc == OP_PROG4);
        is_arr  = is_rd | is_fast | is_qout | is_qio | is_dtr;
        known   = is_cfg | is_ear | is_arr | is_prog;
    end

    // Lane widths: quad I/O and DTR carry the address on four lines.
    always_comb
    begin
        if ((st_r == S_CMD) || (st_r == S_DIN))
        begin
            lanes4 = quad_command_mode_i;
        end
        else
        begin
            lanes4 = quad_command_mode_i | is_qio | is_dtr;
        end
        out4 = quad_command_mode_i | is_qout | is_qio | is_dtr;
        inc  = lanes4 ? 6'h04 : 6'h01;
    end

    // Address length comes from the select flag or a four byte opcode.
    assign abits = (long_address_select_i | four_b) ? ABITS_LONG : ABITS_SHORT;

    // Dummy clocks per command; a fast quad clock needs them for C8.
    always_comb
    begin
        dum = 4'h0;
        if (is_cfg)
        begin
            dum = quad_command_mode_i ? DUM_CFG_QUAD : DUM_CFG_SER;
        end
        else if (is_ear && quad_command_mode_i && sclk_fast_i)
        begin
            dum = DUM_EAR_FAST;
        end
        else if (is_fast || is_qout)
        begin
            dum = DUM_FAST;
        end
        else if (is_qio)
        begin
            dum = DUM_QIO;
        end
        else if (is_dtr)
        begin
            dum = DUM_DTR;
        end
    end

    // Input sampling: rising edges, plus falling ones for DTR address.
    assign samp = rise | (fall & is_dtr & ((st_r == S_ADDR) || (st_r == S_MODE)));
    assign sh_nxt   = lanes4 ? {sh_r[27:0], io_s} : {sh_r[30:0], io_s[0]};
    assign bits_inc = bits_r + inc;
    assign addr_done = (st_r == S_ADDR) && samp && (bits_inc == abits);
    assign byte_done = (st_r == S_DIN) && rise && (bits_inc == BYTE_BITS);

    // The top byte comes from the extended register only in short mode.
    assign a_new = (abits == ABITS_LONG) ? sh_nxt : {ext_addr_i, sh_nxt[23:0]};

    // Dispatch happens the cycle after the eighth opcode bit.
    assign disp = (st_r == S_CMD) && (bits_r == BYTE_BITS);
    assign disp_ign = !known || (is_prog && !write_enable_latch_i)
                    || ((is_cfg || is_arr) && write_in_progress_flag_i);

    // Wrap keeps the address inside its section; otherwise it counts up.
    always_comb
    begin
        unique case (wrap_len_i)
            WRAP_16: wmask = MASK_16;
            WRAP_32: wmask = MASK_32;
            default: wmask = MASK_64;
        endcase
        addr_adv = addr_r + 32'h1;
        if (wrap_en_i && (is_qio || is_dtr))
        begin
            addr_adv = {addr_r[31:8], (addr_r[7:0] & ~wmask) | (addr_adv[7:0] & wmask)};
        end
    end

    // Output edges: falling edges, both edges for DTR.
    assign oedge = (st_r == S_DOUT) && (fall || (is_dtr && rise));

    // Sequencer; chip select high aborts any frame.
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            st_r   <= S_IDLE;
            bits_r <= 6'h00;
            sh_r   <= 32'h0;
            op_r   <= 8'h00;
            addr_r <= 32'h0;
            mode_r <= 8'h00;
        end
        else if (csn_s)
        begin
            st_r   <= S_IDLE;
            bits_r <= 6'h00;
        end
        else
        begin
            unique case (st_r)
                S_IDLE:
                begin
                    st_r <= S_CMD;
                end
                S_CMD:
                begin
                    if (rise)
                    begin
                        sh_r   <= sh_nxt;
                        bits_r <= bits_inc;
                    end
                    else if (disp)
                    begin
                        op_r   <= sh_r[7:0];
                        bits_r <= 6'h00;
                        if (disp_ign)
                            st_r <= S_IGN;
                        else if (!is_ear)
                            st_r <= S_ADDR;
                        else if (dum != 4'h0)
                            st_r <= S_DUMMY;
                        else
                            st_r <= S_DOUT;
                    end
                end
                S_ADDR:
                begin
                    if (samp)
                    begin
                        sh_r   <= sh_nxt;
                        bits_r <= bits_inc;
                    end
                    if (addr_done)
                    begin
                        addr_r <= a_new;
                        bits_r <= 6'h00;
                        if (is_qio || is_dtr)
                            st_r <= S_MODE;
                        else if (is_prog)
                            st_r <= S_DIN;
                        else if (dum != 4'h0)
                            st_r <= S_DUMMY;
                        else
                            st_r <= S_DOUT;
                    end
                end
                S_MODE:
                begin
                    if (samp)
                    begin
                        sh_r   <= sh_nxt;
                        bits_r <= bits_inc;
                        if (bits_inc == BYTE_BITS)
                        begin
                            mode_r <= sh_nxt[7:0];
                            bits_r <= 6'h00;
                            // A forbidden pattern leaves the frame unanswered.
                            st_r   <= (sh_nxt[5:4] == CRM_BAD) ? S_IGN : S_DUMMY;
                        end
                    end
                end
                S_DUMMY:
                begin
                    if (rise)
                    begin
                        bits_r <= bits_inc;
                        if (bits_r[3:0] + 4'h1 == dum)
                        begin
                            bits_r <= 6'h00;
                            st_r   <= S_DOUT;
                        end
                    end
                end
                S_DOUT:
                begin
                    // Array reads advance once per byte; register reads repeat.
                    if (oedge && (obits_r == 4'h0) && is_arr)
                        addr_r <= addr_adv;
                end
                S_DIN:
                begin
                    if (rise)
                    begin
                        sh_r   <= sh_nxt;
                        bits_r <= (bits_inc == BYTE_BITS) ? 6'h00 : bits_inc;
                    end
                end
                S_IGN:
                begin
                    st_r <= S_IGN;
                end
            endcase
        end
    end

    // Refusals are reported as a one-cycle pulse.
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
            reject_o <= 1'b0;
        else
            reject_o <= disp && !csn_s && disp_ign;
    end

    // Byte source: register value, extended register, or array.
    assign src_byte = is_cfg ? cfg_data_i : (is_ear ? ext_addr_i : mem_data_i);
    assign cur_byte = (obits_r == 4'h0) ? src_byte : ob_r;
    assign mem_addr_o = addr_r;

    // Output shifter sends the top bits first and drives only when reading.
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            ob_r    <= 8'h00;
            obits_r <= 4'h0;
            io_o    <= 4'h0;
            io_oe_o <= 4'h0;
        end
        else if (st_r != S_DOUT)
        begin
            obits_r <= 4'h0;
            io_oe_o <= 4'h0;
        end
        else if (oedge)
        begin
            if (out4)
            begin
                io_o    <= cur_byte[7:4];
                ob_r    <= {cur_byte[3:0], 4'h0};
                io_oe_o <= 4'hf;
                obits_r <= (obits_r == 4'h0) ? 4'h4 : obits_r - 4'h4;
            end
            else
            begin
                io_o    <= {2'h0, cur_byte[7], 1'h0};
                ob_r    <= {cur_byte[6:0], 1'h0};
                io_oe_o <= 4'h2;
                obits_r <= (obits_r == 4'h0) ? 4'h7 : obits_r - 4'h1;
            end
        end
    end

    // Page load: a column that wraps in the page, so newest bytes win.
    always_ff @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            col_r        <= 8'h00;
            scol_r       <= 8'h00;
            pcnt_r       <= 9'h000;
            prog_start_o <= 1'b0;
            prog_addr_o  <= 32'h0;
            prog_len_o   <= 9'h000;
        end
        else
        begin
            prog_start_o <= 1'b0;
            if (addr_done && is_prog)
            begin
                col_r  <= a_new[7:0];
                scol_r <= a_new[7:0];
                pcnt_r <= 9'h000;
            end
            else if (byte_done)
            begin
                col_r  <= col_r + 8'h01;
                pcnt_r <= (pcnt_r == PAGE_SIZE) ? PAGE_SIZE : pcnt_r + 9'h001;
            end
            // The frame must end on a byte boundary with data loaded.
            if (csn_s && (st_r == S_DIN) && (bits_r == 6'h00) && (pcnt_r != 9'h000))
            begin
                prog_start_o <= 1'b1;
                prog_addr_o  <= {addr_r[31:8], (pcnt_r == PAGE_SIZE) ? col_r : scol_r};
                prog_len_o   <= pcnt_r;
            end
        end
    end

    // Page buffer written one byte at a time from the serial side.
    sfr_page_buf u_buf (
        .clk_i   (clk_i),
        .we_i    (byte_done && !csn_s),
        .waddr_i (col_r),
        .wdata_i (sh_nxt[7:0]),
        .raddr_i (pb_raddr_i),
        .rdata_o (pb_rdata_o)
    );

    // Checks on the sequencer and shifters.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    a_busy_reject: assert property (disp && !csn_s && is_arr && write_in_progress_flag_i
        |=> st_r == S_IGN && reject_o) else $error("read accepted while busy");
    a_cfg_reject: assert property (disp && !csn_s && is_cfg && write_in_progress_flag_i
        |=> st_r == S_IGN) else $error("config read accepted while busy");
    a_wel_gate: assert property (disp && !csn_s && is_prog && !write_enable_latch_i
        |=> st_r == S_IGN) else $error("program without write latch");
    a_long_addr: assert property (addr_done && !csn_s && abits == ABITS_LONG
        |=> addr_r == $past(sh_nxt)) else $error("long address mangled");
    a_ext_upper: assert property (addr_done && !csn_s && abits == ABITS_SHORT
        |=> addr_r[31:24] == $past(ext_addr_i)) else $error("top byte wrong");
    a_addr_step: assert property (st_r == S_DOUT && oedge && obits_r == 4'h0 && is_arr
        && !(wrap_en_i && (is_qio || is_dtr)) && !csn_s
        |=> addr_r == $past(addr_r) + 32'h1) else $error("address not advanced");
    a_wrap_sect: assert property (st_r == S_DOUT && oedge && !csn_s && wrap_en_i && is_qio
        |=> (addr_r & ~{24'h0, wmask}) == $past(addr_r & ~{24'h0, wmask}))
        else $error("wrap left its section");
    a_so_fall: assert property (st_r == S_DOUT && !out4 && $changed(io_o)
        |-> $past(fall)) else $error("serial output moved off falling edge");
    a_prog_bound: assert property (csn_s && st_r == S_DIN && bits_r != 6'h00
        |=> !prog_start_o) else $error("partial byte started program");
    a_prog_len: assert property (prog_start_o |-> prog_len_o != 9'h000
        && prog_len_o <= PAGE_SIZE) else $error("program length out of range");

    c_cfg_out: cover property (st_r == S_DOUT && is_cfg && oedge);
    c_dtr_out: cover property (st_r == S_DOUT && is_dtr && rise);
    c_prog: cover property (prog_start_o && prog_len_o == PAGE_SIZE);
    c_reject: cover property (reject_o);

endmodule

// *** verif/sfr_host_model.sv ***
// Host controller model: drives chip select, serial clock and SI.
// Assumes the bench resolves SO from the device enable, pulled up.
`timescale 1ns/1ps
module sfr_host_model (
    // Pacing clock.
    input  wire logic clk_i,
    // Resolved SO line.
    input  wire logic so_i,
    // Host pins.
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      si_o
);
    // Serial clock stands low and select high between frames.
    initial
    begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        si_o   = 1'b1;
    end
    // Five system clocks per half period leave the synchroniser room.
    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // Send nout bits MSB first, then sample nin bits at rising edges.
    // Single-line frames only, so no mode byte with bits 5:4 of 10 is sent.
    task automatic frame(input logic [63:0] out, input int nout, input int nin,
                         output logic [31:0] got);
        got = '0;
        cs_n_o = 1'b0;
        tick(5);
        for (int i = 0; i < nout + nin; i++)
        begin
            si_o = (i < nout) ? out[63-i] : 1'b1;
            tick(5);
            sclk_o = 1'b1;
            got = (i < nout) ? got : {got[30:0], so_i};
            tick(5);
            sclk_o = 1'b0;
        end
        tick(5);
        cs_n_o = 1'b1;
        tick(10);
    endtask
endmodule

// *** verif/tb_top.sv ***
// Bench for the flash front end: host model frames plus flag levels.
// Assumes the array returns address xor 5a and config address plus 11.
`timescale 1ns/1ps
module tb_top;
    import sfr_pkg::*;
    logic        clk_i = 1'b0;      // System clock.
    logic        resetn_i = 1'b0;   // Reset, active low.
    logic        sclk_i, cs_n_i, si;
    logic [3:0]  io_o, io_oe_o;
    logic        write_in_progress_flag = 1'b0, write_enable_latch = 1'b0, las = 1'b0;
    logic [7:0]  ext = 8'h7e;
    logic [7:0]  pb_raddr = 8'h00;
    logic [7:0]  pb_rdata;
    logic [31:0] mem_addr, paddr, got;
    logic [8:0]  plen;
    logic        rej, pstart;
    int          err_count = 0, comparisons = 0, rej_n = 0, oe_n = 0, prog_n = 0;
    logic [7:0]  ops [4] = '{OP_RD3, OP_FAST3, OP_CFG_NV, OP_DTR3};
    wire  [3:0]  io_i = {2'h3, io_oe_o[1] ? io_o[1] : 1'b1, si};
    always #50 clk_i = ~clk_i;
    sfr_core uut (.clk_i(clk_i), .resetn_i(resetn_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
        .io_i(io_i), .io_o(io_o), .io_oe_o(io_oe_o), .write_in_progress_flag_i(write_in_progress_flag),
        .write_enable_latch_i(write_enable_latch), .long_address_select_i(las), .quad_command_mode_i(1'b0),
        .sclk_fast_i(1'b0), .wrap_en_i(1'b0), .wrap_len_i(2'h0), .ext_addr_i(ext),
        .mem_addr_o(mem_addr), .mem_data_i(mem_addr[7:0] ^ 8'h5a),
        .cfg_data_i(mem_addr[7:0] + 8'h11), .reject_o(rej), .prog_start_o(pstart),
        .prog_addr_o(paddr), .prog_len_o(plen), .pb_raddr_i(pb_raddr), .pb_rdata_o(pb_rdata));
    sfr_host_model host (.clk_i(clk_i), .so_i(io_i[1]), .sclk_o(sclk_i), .cs_n_o(cs_n_i),
        .si_o(si));
    // Pulses and drive cycles are counted so frames can be judged after.
    always @(posedge clk_i)
    begin
        rej_n  <= rej_n + int'(rej === 1'b1);
        oe_n   <= oe_n + int'(io_oe_o !== 4'h0);
        prog_n <= prog_n + int'(pstart === 1'b1);
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e)
        begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic test_done;
        $display("errors=%0d comparisons=%0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // A hang is cut off well past the expected 0.57 ms of frames.
    initial
    begin
        #3000000;
        err_count++;
        test_done;
    end
    initial
    begin
        int r0, o0, p0;
        repeat (20) @(negedge clk_i);
        resetn_i = 1'b1;
        host.tick(5);
        host.frame({OP_RD3, 24'h1234fe, 32'h0}, 32, 16, got);
        chk(got, 32'ha4a5);
        // The closing clock fall starts a third byte, so the address is one further.
        chk(mem_addr, 32'h7e123501);
        las = 1'b1;
        host.frame({OP_RD3, 32'h00abcdef, 24'h0}, 40, 8, got);
        chk(got, 32'hb5);
        chk(mem_addr, 32'h00abcdf1);
        las = 1'b0;
        host.frame({OP_FAST3, 24'h000010, 32'h0}, 40, 8, got);
        chk(got, 32'h4a);
        host.frame({OP_CFG_NV, 24'h000002, 32'h0}, 40, 8, got);
        chk(got, 32'h13);
        // A fresh extended register value must reach the pin, then the old one returns.
        ext = 8'hc3;
        host.frame({OP_EAR, 56'h0}, 8, 8, got);
        chk(got, 32'hc3);
        ext = 8'h7e;
        // A busy device answers no read and drives nothing.
        write_in_progress_flag = 1'b1;
        foreach (ops[k])
        begin
            r0 = rej_n;
            o0 = oe_n;
            host.frame({ops[k], 24'h000100, 32'h0}, 32, 16, got);
            chk(rej_n - r0, 1);
            chk(oe_n - o0, 0);
        end
        write_in_progress_flag = 1'b0;
        // Latch clear, then a frame ending mid-byte: neither programs.
        p0 = prog_n;
        for (int k = 0; k < 2; k++)
        begin
            write_enable_latch = k[0];
            host.frame({OP_PROG3, 24'h004400, 16'h1122, 16'h0}, 48 - 4 * k, 0, got);
            chk(prog_n - p0, 0);
        end
        host.frame({OP_PROG3, 24'h0044ff, 16'ha53c, 16'h0}, 48, 0, got);
        chk(prog_n - p0, 1);
        chk({23'h0, plen}, 32'h2);
        chk(paddr, 32'h7e0044ff);
        // The first byte sits in the last column of the page.
        pb_raddr = 8'hff;
        host.tick(2);
        chk(pb_rdata, 32'ha5);
        pb_raddr = 8'h00;
        host.tick(2);
        chk(pb_rdata, 32'h3c);
        test_done;
    end
endmodule
